// *** hw/ctae_exec_unit.v ***
/*
 * Transfer, exchange and add execution unit of an 8-bit core, with four
 * banks of eight byte registers, status word, program counter, internal
 * high-speed RAM and an other-area data window, reached over Wishbone.
 * Assumes a classic Wishbone master on sys_clk and a synchronous system.
 */
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ctae_defines.vh"

module ctae_exec_unit #(
	parameter WAIT_W = 4
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         busy_q
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg  [7:0]        regFile [0:31];
	reg  [7:0]        fastRam [0:255];
	reg  [7:0]        otherMem [0:255];
	reg               state_q;
	reg  [3:0]        op_q;
	reg  [2:0]        rSel_q;
	reg  [1:0]        rpSel_q;
	reg  [15:0]       opnd_q;
	reg  [7:0]        psw_q;
	reg  [15:0]       pc_q;
	reg  [WAIT_W-1:0] rdWait_q;
	reg  [WAIT_W-1:0] wrWait_q;
	reg  [7:0]        cnt_q;
	reg  [7:0]        lastCyc_q;
	reg               err_q;
	reg  [15:0]       chkAddr_q;

	wire [1:0]  bank     = {psw_q[`CTAE_PSW_RBS1], psw_q[`CTAE_PSW_RBS0]};
	wire [4:0]  rIdx     = {bank, rSel_q};
	wire [4:0]  aIdx     = {bank, 3'h1};
	wire [4:0]  xIdx     = {bank, 3'h0};
	wire [4:0]  pLoIdx   = {bank, rpSel_q, 1'b0};
	wire [4:0]  pHiIdx   = {bank, rpSel_q, 1'b1};
	wire [7:0]  accA     = regFile[aIdx];
	wire [15:0] accAX    = {accA, regFile[xIdx]};
	wire [15:0] pairVal  = {regFile[pHiIdx], regFile[pLoIdx]};
	wire [7:0]  regVal   = regFile[rIdx];

	// ****************************************************************
	// Memory areas
	// ****************************************************************
	wire        inFast   = (opnd_q >= `CTAE_SADDR_LO) && (opnd_q <= `CTAE_SADDR_HI);
	wire [15:0] fastOfsW = opnd_q - `CTAE_SADDR_LO;
	wire [7:0]  fastOfs  = fastOfsW[7:0];
	wire [7:0]  fastOfs1 = fastOfs + 8'h01;
	wire [7:0]  othOfs   = opnd_q[7:0];
	wire [7:0]  othOfs1  = othOfs + 8'h01;
	wire [7:0]  memByte  = inFast ? fastRam[fastOfs] : otherMem[othOfs];
	wire [7:0]  memByte1 = inFast ? fastRam[fastOfs1] : otherMem[othOfs1];

	// ****************************************************************
	// Byte add
	// ****************************************************************
	wire [7:0]  addSrc   = (op_q == `CTAE_OP_ADD_AM) ? memByte : opnd_q[7:0];
	wire [8:0]  sum9     = {1'b0, accA} + {1'b0, addSrc};
	wire [4:0]  sumLo    = {1'b0, accA[3:0]} + {1'b0, addSrc[3:0]};
	wire [15:0] brTarget = pc_q + {{8{opnd_q[7]}}, opnd_q[7:0]};

	// ****************************************************************
	// Address operand checks
	// ****************************************************************
	wire chkSaddr  = (chkAddr_q >= `CTAE_SADDR_LO) && (chkAddr_q <= `CTAE_SADDR_HI);
	wire chkSaddrp = chkSaddr && !chkAddr_q[0];
	wire chkSfr    = (chkAddr_q >= `CTAE_SFR_LO)
		&& !((chkAddr_q >= `CTAE_SFR_GAP_LO) && (chkAddr_q <= `CTAE_SFR_GAP_HI));
	wire chkSfrp   = chkSfr && !chkAddr_q[0];
	wire chkAbsW   = !chkAddr_q[0];
	wire chkBit    = accA[chkAddr_q[2:0]];
	wire [15:0] callTgt = {`CTAE_CALL_BASE, chkAddr_q[10:0]};
	wire [15:0] tblTgt  = `CTAE_TBL_BASE | {10'h000, chkAddr_q[4:0], 1'b0};

	// ****************************************************************
	// Command admission and cycle count
	// ****************************************************************
	wire        busWr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	wire [3:0]  newOp    = wb_dat_i[3:0];
	wire [1:0]  newRp    = wb_dat_i[9:8];
	wire        cmdWr    = busWr && (wb_adr_i == `CTAE_OFS_CMD) && wb_sel_i[0] && wb_sel_i[1];
	wire        pairOp   = (newOp == `CTAE_OP_WORD_MOVE_AR) || (newOp == `CTAE_OP_WORD_MOVE_RA)
		|| (newOp == `CTAE_OP_WORD_EXCHANGE_AR);
	wire        wordMem  = (newOp == `CTAE_OP_WORD_MOVE_AM) || (newOp == `CTAE_OP_WORD_MOVE_MA);
	wire        cmdBad   = (pairOp && (newRp == 2'h0)) || (wordMem && opnd_q[0]);
	wire [7:0]  nWait    = {{(8-WAIT_W){1'b0}}, rdWait_q};
	wire [7:0]  mWait    = {{(8-WAIT_W){1'b0}}, wrWait_q};
	reg  [7:0]  cycCount;

	always @*
	begin
		case (newOp)
			`CTAE_OP_MOV_AR, `CTAE_OP_MOV_RA, `CTAE_OP_XCH_AR: cycCount = `CTAE_CYC_RR;
			`CTAE_OP_MOV_RI, `CTAE_OP_WORD_MOVE_AR, `CTAE_OP_WORD_MOVE_RA,
			`CTAE_OP_WORD_EXCHANGE_AR, `CTAE_OP_ADD_AI: cycCount = `CTAE_CYC_IMM;
			`CTAE_OP_WORD_MOVE_RI: cycCount = `CTAE_CYC_WIMM;
			`CTAE_OP_MOV_AM, `CTAE_OP_ADD_AM:
				cycCount = inFast ? `CTAE_CYC_MEM : `CTAE_CYC_MEMX + nWait;
			`CTAE_OP_MOV_MA: cycCount = inFast ? `CTAE_CYC_MEM : `CTAE_CYC_MEMX + mWait;
			`CTAE_OP_XCH_AM: cycCount = inFast ? `CTAE_CYC_MEM : `CTAE_CYC_XCHX + nWait + mWait;
			`CTAE_OP_WORD_MOVE_AM:
				cycCount = inFast ? `CTAE_CYC_WMEM : `CTAE_CYC_WMEMX + nWait + nWait;
			`CTAE_OP_WORD_MOVE_MA:
				cycCount = inFast ? `CTAE_CYC_WMEM : `CTAE_CYC_WMEMX + mWait + mWait;
			default: cycCount = `CTAE_CYC_BR;
		endcase
	end

	function [31:0] laneMerge;
		input [31:0] oldW;
		input [31:0] newW;
		input [3:0]  sel;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				laneMerge[8*k +: 8] = sel[k] ? newW[8*k +: 8] : oldW[8*k +: 8];
		end
	endfunction

	// ****************************************************************
	// Wishbone slave: ack one cycle after the strobe, writes at ack edge
	// ****************************************************************
	reg [31:0] rdData;

	always @*
	begin
		if (wb_adr_i == `CTAE_OFS_CMD)
			rdData = {22'h0, rpSel_q, 1'b0, rSel_q, op_q};
		else if (wb_adr_i == `CTAE_OFS_OPND)
			rdData = {16'h0, opnd_q};
		else if (wb_adr_i == `CTAE_OFS_STAT)
			rdData = {16'h0, lastCyc_q, 6'h0, err_q, busy_q};
		else if (wb_adr_i == `CTAE_OFS_PSW)
			rdData = {24'h0, psw_q};
		else if (wb_adr_i == `CTAE_OFS_WAIT)
			rdData = {24'h0, mWait[3:0], nWait[3:0]};
		else if (wb_adr_i == `CTAE_OFS_REGLO)
			rdData = {regFile[{bank, 3'h3}], regFile[{bank, 3'h2}], accA, regFile[xIdx]};
		else if (wb_adr_i == `CTAE_OFS_REGHI)
			rdData = {regFile[{bank, 3'h7}], regFile[{bank, 3'h6}],
				regFile[{bank, 3'h5}], regFile[{bank, 3'h4}]};
		else if (wb_adr_i == `CTAE_OFS_PC)
			rdData = {16'h0, pc_q};
		else if (wb_adr_i == `CTAE_OFS_ACHK)
			rdData = {26'h0, chkBit, chkAbsW,
				chkSfrp, chkSfr, chkSaddrp, chkSaddr};
		else if (wb_adr_i == `CTAE_OFS_VEC)
			rdData = {tblTgt, callTgt};
		else
			rdData = 32'h0000_0000;
	end

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o)
				wb_dat_o <= rdData;
		end
	end

	// ****************************************************************
	// Control registers and execution sequencer
	// ****************************************************************
	reg [31:0] wMerge;

	always @*
	begin
		case (wb_adr_i)
			`CTAE_OFS_OPND: wMerge = laneMerge({16'h0, opnd_q}, wb_dat_i, wb_sel_i);
			`CTAE_OFS_PSW:  wMerge = laneMerge({24'h0, psw_q}, wb_dat_i, wb_sel_i);
			`CTAE_OFS_WAIT: wMerge = laneMerge({24'h0, mWait[3:0], nWait[3:0]}, wb_dat_i,
				wb_sel_i);
			`CTAE_OFS_PC:   wMerge = laneMerge({16'h0, pc_q}, wb_dat_i, wb_sel_i);
			default:        wMerge = laneMerge({16'h0, chkAddr_q}, wb_dat_i, wb_sel_i);
		endcase
	end

	wire commit = (state_q == ST_EXEC) && (cnt_q == 8'h01);

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q   <= ST_IDLE;
			busy_q    <= 1'b0;
			op_q      <= 4'h0;
			rSel_q    <= 3'h0;
			rpSel_q   <= 2'h0;
			opnd_q    <= 16'h0000;
			psw_q     <= `CTAE_PSW_RESET;
			pc_q      <= 16'h0000;
			rdWait_q  <= {WAIT_W{1'b0}};
			wrWait_q  <= {WAIT_W{1'b0}};
			cnt_q     <= 8'h00;
			lastCyc_q <= 8'h00;
			err_q     <= 1'b0;
			chkAddr_q <= 16'h0000;
		end
		else
		begin
			if (busWr && !busy_q)
			begin
				if (wb_adr_i == `CTAE_OFS_OPND)
					opnd_q <= wMerge[15:0];
				else if (wb_adr_i == `CTAE_OFS_PSW)
					psw_q <= wMerge[7:0];
				else if (wb_adr_i == `CTAE_OFS_WAIT)
				begin
					rdWait_q <= wMerge[WAIT_W-1:0];
					wrWait_q <= wMerge[WAIT_W+3:4];
				end
				else if (wb_adr_i == `CTAE_OFS_PC)
					pc_q <= wMerge[15:0];
				else if (wb_adr_i == `CTAE_OFS_ACHK)
					chkAddr_q <= wMerge[15:0];
			end
			case (state_q)
				ST_IDLE:
				begin
					if (cmdWr && !busy_q)
					begin
						op_q    <= newOp;
						rSel_q  <= wb_dat_i[6:4];
						rpSel_q <= newRp;
						err_q   <= cmdBad;
						if (!cmdBad)
						begin
							state_q   <= ST_EXEC;
							busy_q    <= 1'b1;
							cnt_q     <= cycCount;
							lastCyc_q <= cycCount;
						end
					end
				end
				default:
				begin
					cnt_q <= cnt_q - 8'h01;
					if (commit)
					begin
						state_q <= ST_IDLE;
						busy_q  <= 1'b0;
						if ((op_q == `CTAE_OP_ADD_AI) || (op_q == `CTAE_OP_ADD_AM))
						begin
							psw_q[`CTAE_PSW_CY] <= sum9[8];
							psw_q[`CTAE_PSW_AC] <= sumLo[4];
							psw_q[`CTAE_PSW_Z]  <= (sum9[7:0] == 8'h00);
						end
						if (op_q == `CTAE_OP_BR)
							pc_q <= brTarget;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Data path commit; transfers never touch the flags
	// ****************************************************************
	always @(posedge sys_clk)
	begin
		if (commit)
		begin
			case (op_q)
				`CTAE_OP_MOV_RI: regFile[rIdx] <= opnd_q[7:0];
				`CTAE_OP_MOV_AR: regFile[aIdx] <= regVal;
				`CTAE_OP_MOV_RA: regFile[rIdx] <= accA;
				`CTAE_OP_MOV_AM: regFile[aIdx] <= memByte;
				`CTAE_OP_XCH_AR:
				begin
					regFile[aIdx] <= regVal;
					regFile[rIdx] <= accA;
				end
				`CTAE_OP_XCH_AM, `CTAE_OP_MOV_MA:
				begin
					if (op_q == `CTAE_OP_XCH_AM)
						regFile[aIdx] <= memByte;
					if (inFast)
						fastRam[fastOfs] <= accA;
					else
						otherMem[othOfs] <= accA;
				end
				`CTAE_OP_WORD_MOVE_RI:
				begin
					regFile[pLoIdx] <= opnd_q[7:0];
					regFile[pHiIdx] <= opnd_q[15:8];
				end
				`CTAE_OP_WORD_MOVE_AR, `CTAE_OP_WORD_EXCHANGE_AR:
				begin
					regFile[xIdx] <= pairVal[7:0];
					regFile[aIdx] <= pairVal[15:8];
					if (op_q == `CTAE_OP_WORD_EXCHANGE_AR)
					begin
						regFile[pLoIdx] <= accAX[7:0];
						regFile[pHiIdx] <= accAX[15:8];
					end
				end
				`CTAE_OP_WORD_MOVE_RA:
				begin
					regFile[pLoIdx] <= accAX[7:0];
					regFile[pHiIdx] <= accAX[15:8];
				end
				`CTAE_OP_WORD_MOVE_AM:
				begin
					regFile[xIdx] <= memByte;
					regFile[aIdx] <= memByte1;
				end
				`CTAE_OP_WORD_MOVE_MA:
				begin
					if (inFast)
					begin
						fastRam[fastOfs]  <= accAX[7:0];
						fastRam[fastOfs1] <= accAX[15:8];
					end
					else
					begin
						otherMem[othOfs]  <= accAX[7:0];
						otherMem[othOfs1] <= accAX[15:8];
					end
				end
				`CTAE_OP_ADD_AI, `CTAE_OP_ADD_AM: regFile[aIdx] <= sum9[7:0];
				default:
				begin
					// Branch updates only the program counter, in the sequencer
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** hw/ctae_defines.vh ***
/*
 * Constants of the transfer and add execution unit: register offsets,
 * command encodings, status word fields, address windows, cycle counts.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef CTAE_DEFINES_VH
`define CTAE_DEFINES_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CTAE_OFS_CMD    8'h00
`define CTAE_OFS_OPND   8'h04
`define CTAE_OFS_STAT   8'h08
`define CTAE_OFS_PSW    8'h0C
`define CTAE_OFS_WAIT   8'h10
`define CTAE_OFS_REGLO  8'h14
`define CTAE_OFS_REGHI  8'h18
`define CTAE_OFS_PC     8'h1C
`define CTAE_OFS_ACHK   8'h20
`define CTAE_OFS_VEC    8'h24

// ****************************************************************
// Commands
// ****************************************************************
`define CTAE_OP_MOV_RI   4'h0
`define CTAE_OP_MOV_AR   4'h1
`define CTAE_OP_MOV_RA   4'h2
`define CTAE_OP_MOV_AM   4'h3
`define CTAE_OP_MOV_MA   4'h4
`define CTAE_OP_XCH_AR   4'h5
`define CTAE_OP_XCH_AM   4'h6
`define CTAE_OP_WORD_MOVE_RI  4'h7
`define CTAE_OP_WORD_MOVE_AR  4'h8
`define CTAE_OP_WORD_MOVE_RA  4'h9
`define CTAE_OP_WORD_EXCHANGE_AR  4'hA
`define CTAE_OP_WORD_MOVE_AM  4'hB
`define CTAE_OP_WORD_MOVE_MA  4'hC
`define CTAE_OP_ADD_AI   4'hD
`define CTAE_OP_ADD_AM   4'hE
`define CTAE_OP_BR       4'hF

// ****************************************************************
// Status word bit positions
// ****************************************************************
`define CTAE_PSW_IE     7
`define CTAE_PSW_Z      6
`define CTAE_PSW_RBS1   5
`define CTAE_PSW_AC     4
`define CTAE_PSW_RBS0   3
`define CTAE_PSW_NMI_SERVICING_FLAG   1
`define CTAE_PSW_CY     0
`define CTAE_PSW_RESET  8'h02

// ****************************************************************
// Address windows
// ****************************************************************
`define CTAE_SADDR_LO   16'hFE20
`define CTAE_SADDR_HI   16'hFF1F
`define CTAE_SFR_LO     16'hFF00
`define CTAE_SFR_GAP_LO 16'hFFD0
`define CTAE_SFR_GAP_HI 16'hFFDF
`define CTAE_CALL_BASE  5'h01
`define CTAE_TBL_BASE   16'h0040

// ****************************************************************
// Cycle counts (internal / other area base)
// ****************************************************************
`define CTAE_CYC_RR     8'h02
`define CTAE_CYC_IMM    8'h04
`define CTAE_CYC_WIMM   8'h06
`define CTAE_CYC_MEM    8'h08
`define CTAE_CYC_MEMX   8'h09
`define CTAE_CYC_XCHX   8'h0A
`define CTAE_CYC_WMEM   8'h0A
`define CTAE_CYC_WMEMX  8'h0C
`define CTAE_CYC_BR     8'h06

`endif

// *** bench/ctae_exec_unit_asserts.sv ***
/* Checker for the exec unit: bus handshake and command timing.
   Assumes binding to ctae_exec_unit, one clock, async reset. */
`timescale 1ns/1ns
`default_nettype none
module ctae_exec_unit_asserts (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        busy_q
);
	wire logic       cmdGo;
	wire logic [3:0] op;
	assign cmdGo = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 8'h00)
		& (wb_sel_i[1:0] == 2'h3) & !busy_q;
	assign op = wb_dat_i[3:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over one cycle");
	AST_ACK_REPLY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_IMM_CNT: assert property (cmdGo && op == 4'hD |=> busy_q[*4] ##1 !busy_q)
		else $error("add immediate count wrong");
	AST_MOVI_CNT: assert property (cmdGo && op == 4'h0 |=> busy_q[*4] ##1 !busy_q)
		else $error("move immediate count wrong");
	AST_WPAIR_CNT: assert property (cmdGo && op == 4'h8 && wb_dat_i[9:8] != 2'h0
		|=> busy_q[*4] ##1 !busy_q) else $error("word pair move count wrong");
	AST_WPAIR_REF: assert property (cmdGo && op >= 4'h8 && op <= 4'hA
		&& wb_dat_i[9:8] == 2'h0 |=> !busy_q[*2]) else $error("pair zero not refused");
	AST_BR_CNT: assert property (cmdGo && op == 4'hF |=> busy_q[*6] ##1 !busy_q)
		else $error("branch count wrong");
	AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h24 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_BUSY_CAUSE: assert property ($rose(busy_q) |-> $past(cmdGo))
		else $error("busy without command");
endmodule
`default_nettype wire

// *** bench/ctae_wb_master.sv ***
/* Classic Wishbone master model driving the exec unit.
   Assumes callers enter its task just after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module ctae_wb_master (
	input  wire logic        sys_clk,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	output var  logic        wb_cyc_i,
	output var  logic        wb_stb_i,
	output var  logic        wb_we_i,
	output var  logic [7:0]  wb_adr_i,
	output var  logic [3:0]  wb_sel_i,
	output var  logic [31:0] wb_dat_i,
	output var  logic        tmo
);
	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, tmo} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
	end
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			tmo <= 1'b1;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// Released lines show garbage, not the last value
		wb_adr_i <= ~adr;
		wb_dat_i <= ~wd;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// *** bench/test_cpu_transfer_add_instructions.sv ***
/* Self-checking bench of the transfer and add exec unit.
   Assumes the Wishbone master model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module test_cpu_transfer_add_instructions;
	logic sys_clk, reset, cyc, stb, we, ack, busy, tmo;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wd, rdat, d, st, lo, hi;
	logic [63:0] all;
	logic [15:0] w;
	int bad_count, total_checks;
	ctae_exec_unit u_dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
		.wb_ack_o(ack), .busy_q(busy));
	ctae_wb_master u_bfm (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(rdat), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .tmo(tmo));
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task conclude;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		u_bfm.xfer(1'b1, a, v, x);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		u_bfm.xfer(1'b0, a, 32'h0, v);
	endtask
	// Operand, command, then poll status until idle
	task run(input logic [31:0] c, input logic [31:0] o);
		int n;
		wr(8'h04, o);
		wr(8'h00, c);
		n = 0;
		do
		begin
			rd(8'h08, st);
			n++;
		end while (st[0] !== 1'b0 && n < 40);
		if (n >= 40)
		begin
			bad_count++;
			conclude;
		end
	endtask
	task t_regs;
		for (int r = 0; r < 8; r++)
		begin
			run({25'h0, r[2:0], 4'h0}, 32'hA0 + r);
			chk("count", 32'h04, {24'h0, st[15:8]});
		end
		rd(8'h14, d);
		chk("reglo", 32'hA3A2A1A0, d);
		rd(8'h18, d);
		chk("reghi", 32'hA7A6A5A4, d);
		$display("regs done");
	endtask
	task t_pairs;
		for (int p = 1; p < 4; p++)
		begin
			w = 16'hB100 + p[15:0];
			run({22'h0, p[1:0], 8'h07}, {16'h0, w});
			rd(8'h14, lo);
			rd(8'h18, hi);
			all = {hi, lo};
			chk("pair", {16'h0, w}, {16'h0, all[p*16 +: 16]});
			run({22'h0, p[1:0], 8'h08}, 32'h0);
			chk("count", 32'h04, {24'h0, st[15:8]});
			rd(8'h14, d);
			chk("ax", {16'h0, w}, {16'h0, d[15:0]});
		end
		run(32'h008, 32'h0);
		chk("err", 32'h1, {31'h0, st[1]});
		$display("pairs done");
	endtask
	task t_add;
		wr(8'h0C, 32'h0);
		run(32'h010, 32'hF8);
		run(32'h00D, 32'h08);
		chk("count", 32'h04, {24'h0, st[15:8]});
		rd(8'h0C, d);
		chk("psw", 32'h51, d);
		rd(8'h14, d);
		chk("a", 32'h0, {24'h0, d[15:8]});
		run(32'h010, 32'h01);
		rd(8'h0C, d);
		chk("psw", 32'h51, d);
		run(32'h00D, 32'h02);
		rd(8'h0C, d);
		chk("psw", 32'h00, d);
		$display("add done");
	endtask
	task t_mem;
		wr(8'h10, 32'h23);
		run(32'h010, 32'h5A);
		run(32'h004, 32'h1234);
		chk("count", 32'h0B, {24'h0, st[15:8]});
		run(32'h010, 32'h00);
		run(32'h003, 32'h1234);
		chk("count", 32'h0C, {24'h0, st[15:8]});
		rd(8'h14, d);
		chk("a", 32'h5A, {24'h0, d[15:8]});
		run(32'h004, 32'hFE20);
		chk("count", 32'h08, {24'h0, st[15:8]});
		run(32'h00B, 32'h1235);
		chk("err", 32'h1, {31'h0, st[1]});
		$display("mem done");
	endtask
	task t_misc;
		rd(8'h1C, d);
		run(32'h00F, 32'h05);
		run(32'h00F, 32'hFE);
		rd(8'h1C, lo);
		chk("pc", {16'h0, d[15:0] + 16'h0003}, {16'h0, lo[15:0]});
		wr(8'h20, 32'hFE20);
		rd(8'h20, d);
		chk("achk", 32'h13, {26'h0, d[5:0]});
		wr(8'h20, 32'hFFD4);
		rd(8'h20, d);
		chk("achk", 32'h30, {26'h0, d[5:0]});
		rd(8'h24, d);
		chk("vec", 32'h00680FD4, d);
		rd(8'h30, d);
		chk("unmapped", 32'h0, d);
		wr(8'h0C, 32'h08);
		run(32'h000, 32'h77);
		rd(8'h14, d);
		chk("bank1", 32'h77, {24'h0, d[7:0]});
		wr(8'h0C, 32'h00);
		rd(8'h14, d);
		chk("bank0", 32'h03, {24'h0, d[7:0]});
		$display("misc done");
	endtask
	task t_ops;
		run(32'h010, 32'h3C);
		run(32'h040, 32'hC3);
		run(32'h045, 32'h0);
		chk("count", 32'h02, {24'h0, st[15:8]});
		rd(8'h18, hi);
		chk("e", 32'h3C, {24'h0, hi[7:0]});
		run(32'h022, 32'h0);
		run(32'h041, 32'h0);
		rd(8'h14, d);
		chk("ca", 32'hC33C, {16'h0, d[23:8]});
		run(32'h004, 32'h1240);
		run(32'h010, 32'h11);
		run(32'h006, 32'h1240);
		chk("count", 32'h0F, {24'h0, st[15:8]});
		run(32'h00E, 32'h1240);
		chk("count", 32'h0C, {24'h0, st[15:8]});
		rd(8'h14, d);
		chk("a", 32'h4D, {24'h0, d[15:8]});
		run(32'h007, 32'h4D03);
		run(32'h109, 32'h0);
		rd(8'h14, d);
		chk("bc", 32'h4D034D03, d);
		run(32'h307, 32'h5566);
		run(32'h30A, 32'h0);
		rd(8'h14, lo);
		rd(8'h18, hi);
		chk("word_exchange", 32'h4D035566, {hi[31:16], lo[15:0]});
		run(32'h00C, 32'h1250);
		chk("count", 32'h10, {24'h0, st[15:8]});
		run(32'h007, 32'h0);
		run(32'h00B, 32'h1250);
		chk("count", 32'h12, {24'h0, st[15:8]});
		rd(8'h14, d);
		chk("ax", 32'h5566, {16'h0, d[15:0]});
		$display("ops done");
	endtask
	always @(posedge tmo)
	begin
		bad_count++;
		conclude;
	end
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		bad_count++;
		conclude;
	end
	initial
	begin
		bad_count = 0;
		total_checks = 0;
		reset = 1'b1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rd(8'h0C, d);
		chk("psw", 32'h02, d);
		t_regs;
		t_pairs;
		t_add;
		t_mem;
		t_misc;
		t_ops;
		conclude;
	end
endmodule
bind ctae_exec_unit ctae_exec_unit_asserts u_chk (.sys_clk(sys_clk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.busy_q(busy_q));
`default_nettype wire
